// file: bench/mhtf_fifo_model.sv
// Behavioural transmit FIFO that answers the read pulses of the feed.
module mhtf_fifo_model
  import mhtf_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rd,
  output logic [15:0] data,
  output logic [1:0]  byten,
  output logic        eof,
  output logic        avail,
  output logic        empty
);
  timeunit 1ns;
  timeprecision 1ps;

  mhtf_word_t q[$];
  mhtf_word_t w;

  initial
  begin
    data  = 16'hFFFF;
    byten = BYTEN_NONE;
    eof   = 1'b0;
    avail = 1'b0;
    empty = 1'b1;
  end

  // The bench loads each word up front; packing and the last flag are its job.
  task automatic push(input mhtf_word_t x);
    q.push_back(x);
    empty = 1'b0;
    avail = 1'b1;
  endtask : push

  // The feed samples the word at the edge that closes its read cycle, so the word is
  // put up on the falling edge inside that cycle. Outside it the lanes read empty and
  // the data is scrambled, so an early or a late sample shows up as a wrong word.
  always @(negedge clk)
  begin
    if (rd && q.size() != 0)
    begin
      w = q.pop_front();
      data  <= w.data;
      byten <= w.byten;
      eof   <= w.last;
      empty <= (q.size() == 0);
      avail <= (q.size() != 0);
    end
    else
    begin
      data  <= ~data;
      byten <= BYTEN_NONE;
      eof   <= 1'b0;
    end
  end
endmodule : mhtf_fifo_model

// file: bench/mhtf_top_bench.sv
// Self-checking bench for the host port and transmit feed.
module mhtf_top_bench;
  import mhtf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, cs_n, wr_n, rd_n, rdy_n, en_n, frd, ferr, vld, ordy;
  logic [7:0]  haddr;
  logic [15:0] hdin, hdout, fdat;
  logic [1:0]  fben;
  logic        feof, favail, fempty, rd_q;
  mhtf_word_t  tout;
  mhtf_word_t  got[$];
  logic [15:0] rv;
  int          failures = 0;
  int          n_tests = 0;

  mhtf_top DUT (.REF_CLK(clk), .RST(rst), .HCS_N(cs_n), .HADDR(haddr), .HDATAIN(hdin),
    .HWRITE_N(wr_n), .HREAD_N(rd_n), .HREADY_N(rdy_n), .HDATAOUT_EN_N(en_n), .HDATAOUT(hdout),
    .TX_FIFO_DATA(fdat), .TX_FIFO_BYTEN(fben), .TX_FIFO_AVAIL(favail), .TX_FIFO_EOF(feof),
    .TX_FIFO_EMPTY(fempty), .TX_FIFO_READ(frd), .TX_ERR(ferr), .TX_OUT(tout),
    .TX_OUT_VALID(vld), .TX_OUT_READY(ordy));

  mhtf_fifo_model u_fifo (.clk(clk), .rd(frd), .data(fdat), .byten(fben), .eof(feof),
    .avail(favail), .empty(fempty));

  // ************************************************************
  // Shared checking and bus tasks
  // ************************************************************
  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic host(input logic we, input logic [7:0] a, input logic [15:0] wd);
    int n;
    @(posedge clk);
    cs_n  <= 1'b0;
    haddr <= a;
    hdin  <= wd;
    wr_n  <= !we;
    rd_n  <= we;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (rdy_n !== 1'b0 && n < 8);
    chk(n, 1);
    if (n == 8)
      summarize();
    chk(en_n, we);
    rv = hdout;
    @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({rdy_n, en_n, hdout}, {2'b11, REG_ZERO});
  endtask : host

  task automatic wait_words(input int k);
    int n;
    n = 0;
    while (got.size() < k && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    chk(got.size(), k);
    if (got.size() < k)
      summarize();
  endtask : wait_words

  always @(posedge clk)
  begin
    if (vld === 1'b1 && ordy)
      got.push_back(tout);
    if (!rst)
      chk(rd_q & frd, 1'b0);
    rd_q <= frd;
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    chk({rdy_n, en_n, frd, ferr, vld, hdout}, {5'b11000, REG_ZERO});
    host(1'b0, ADDR_CTRL, REG_ZERO);
    chk(rv, CTRL_RST);
    host(1'b0, ADDR_FRAMES, REG_ZERO);
    chk(rv, REG_ZERO);
  endtask : t_reset

  task automatic t_regs();
    host(1'b1, ADDR_SCRATCH, 16'hA5C3);
    host(1'b0, ADDR_SCRATCH, REG_ZERO);
    chk(rv, 16'hA5C3);
    host(1'b0, 8'h7E, REG_ZERO);
    chk(rv, REG_ZERO);
    @(posedge clk);
    haddr <= ADDR_SCRATCH;
    hdin  <= 16'h1234;
    wr_n  <= 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      #1;
      chk(rdy_n, 1'b1);
    end
    @(posedge clk);
    wr_n <= 1'b1;
    host(1'b0, ADDR_SCRATCH, REG_ZERO);
    chk(rv, 16'hA5C3);
  endtask : t_regs

  // The consumer stalls first, so the two-entry buffer must hold back the feed.
  task automatic t_frames();
    logic [18:0] ex[6];
    ex = '{{16'h1111, 2'h3, 1'b0}, {16'h3333, 2'h3, 1'b0}, {16'h4444, 2'h2, 1'b1},
           {16'h5555, 2'h3, 1'b0}, {16'h6666, 2'h1, 1'b1}, {16'h7777, 2'h3, 1'b1}};
    u_fifo.push({16'h1111, 2'h3, 1'b0});
    u_fifo.push({16'h2222, 2'h0, 1'b0});
    u_fifo.push({16'h3333, 2'h3, 1'b0});
    u_fifo.push({16'h4444, 2'h2, 1'b1});
    u_fifo.push({16'h5555, 2'h3, 1'b0});
    u_fifo.push({16'h6666, 2'h1, 1'b0});
    // A packed word that only the end-of-frame flag closes.
    u_fifo.push({16'h7777, 2'h3, 1'b1});
    @(posedge clk);
    ordy <= 1'b0;
    repeat (30) @(posedge clk);
    chk(got.size(), 0);
    ordy <= 1'b1;
    wait_words(6);
    for (int i = 0; i < 6; i++)
      chk(got[i], ex[i]);
    got.delete();
    host(1'b0, ADDR_FRAMES, REG_ZERO);
    chk(rv, 16'h0003);
  endtask : t_frames

  task automatic t_underrun();
    int n;
    u_fifo.push({16'h7777, 2'h3, 1'b0});
    u_fifo.push({16'h8888, 2'h3, 1'b0});
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (ferr !== 1'b1 && n < 60);
    chk(ferr, 1'b1);
    if (ferr !== 1'b1)
      summarize();
    host(1'b0, ADDR_STAT, REG_ZERO);
    chk(rv[STAT_UNDERRUN_BIT], 1'b1);
    host(1'b1, ADDR_STAT, 16'h0001);
    host(1'b0, ADDR_STAT, REG_ZERO);
    chk(rv, REG_ZERO);
  endtask : t_underrun

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    rst   = 1'b1;
    cs_n  = 1'b1;
    wr_n  = 1'b1;
    rd_n  = 1'b1;
    haddr = 8'h00;
    hdin  = 16'h0000;
    ordy  = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_regs();
    t_frames();
    t_underrun();
    summarize();
  end
endmodule : mhtf_top_bench

// file: inc/mhtf_pkg.sv
// Shared constants, carrier structs and state types for the host port and transmit feed.
package mhtf_pkg;

  // ************************************************************
  // Host register map
  // ************************************************************
  localparam int         HDW_MAX            = 16;
  localparam logic [7:0] ADDR_CTRL          = 8'h00;
  localparam logic [7:0] ADDR_STAT          = 8'h01;
  localparam logic [7:0] ADDR_FRAMES        = 8'h02;
  localparam logic [7:0] ADDR_SCRATCH       = 8'h03;
  localparam int         CTRL_TXEN_BIT      = 0;
  localparam int         STAT_UNDERRUN_BIT  = 0;
  localparam int         STAT_INFRAME_BIT   = 1;
  localparam logic [15:0] CTRL_RST          = 16'h0001;
  localparam logic [15:0] REG_ZERO          = 16'h0000;

  // ************************************************************
  // Transmit word carrier
  // ************************************************************
  localparam logic [1:0] BYTEN_FULL = 2'h3;
  localparam logic [1:0] BYTEN_NONE = 2'h0;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  byten;
    logic        last;
  } mhtf_word_t;

  typedef enum logic [1:0] {H_IDLE, H_WDONE, H_RDONE} mhtf_host_st_t;
  typedef enum logic [1:0] {F_IDLE, F_REQ, F_CAPT}    mhtf_feed_st_t;

  typedef struct packed {
    mhtf_host_st_t host_st;
    mhtf_feed_st_t feed_st;
    logic [15:0]   ctrl;
    logic [15:0]   scratch;
    logic [15:0]   frames;
    logic          underrun;
    logic          in_frame;
    logic          ready_n;
    logic          dout_en_n;
    logic [15:0]   dout;
    logic          rd_pulse;
    logic          tx_err;
  } mhtf_state_t;

  localparam mhtf_state_t ST_RST = '{
    host_st: H_IDLE, feed_st: F_IDLE, ctrl: CTRL_RST, scratch: REG_ZERO,
    frames: REG_ZERO, underrun: 1'b0, in_frame: 1'b0, ready_n: 1'b1,
    dout_en_n: 1'b1, dout: REG_ZERO, rd_pulse: 1'b0, tx_err: 1'b0};

endpackage : mhtf_pkg

// file: logic/mhtf_buf.sv
// Two-entry valid/ready buffer between the FIFO feed and the downstream consumer.
module mhtf_buf
  import mhtf_pkg::*;
#(
  parameter int W     = 19,
  parameter int DEPTH = 2
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
  } mhtf_buf_st_t;

  mhtf_buf_st_t st_r;
  mhtf_buf_st_t st_nxt;
  logic         push;
  logic         pop;

  assign in_ready  = (st_r.count < (AW+1)'(DEPTH));
  assign out_valid = (st_r.count != '0);
  assign out_data  = st_r.mem[st_r.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wr_ptr] = in_data;
      st_nxt.wr_ptr = (st_r.wr_ptr == AW'(DEPTH-1)) ? '0 : st_r.wr_ptr + AW'(1);
    end
    if (pop)
    begin
      st_nxt.rd_ptr = (st_r.rd_ptr == AW'(DEPTH-1)) ? '0 : st_r.rd_ptr + AW'(1);
    end
    st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // A stalled consumer must never cost a word: offers only come with room.
  property p_no_overflow;
    @(posedge clk) disable iff (rst) in_valid |-> in_ready;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("Buffer offered a word while full.");

endmodule : mhtf_buf

// file: logic/mhtf_top.sv
// Host register port and transmit FIFO read feed of the MAC.
// Function
// - The eight-bit address picks at most one internal register for the access.
// - Selected write strobe low stores the write bus into control or scratch; a status write with bit 0 set clears under-run, a frames write clears the count.
// - Selected read strobe low returns the addressed register on the read bus.
// - Transfer-done goes low on a write only after the data is stored.
// - Transfer-done goes low on a read only once read data is ready.
// - Read-bus drive enable is low exactly while valid read data is presented.
// - A transmit word with both byte enables clear is ignored.
// - Upper enable qualifies the upper byte, lower enable the lower byte.
// - Any word with exactly one byte enable set ends the current frame.
// - All host port signals are synchronous to the single system clock.
// - Reset loads CTRL_RST into control, clears the other registers and logic, and holds outputs at inactive levels.
// - Each FIFO word is requested by a one-cycle read pulse, only when wanted.
// - FIFO empty while a frame is being read raises the transmit error output.
module mhtf_top
  import mhtf_pkg::*;
#(
  parameter int DATA_W = 16  // 8 or 16.
)
(
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire logic              HCS_N,
  input  wire logic [7:0]        HADDR,
  input  wire logic [DATA_W-1:0] HDATAIN,
  input  wire logic              HWRITE_N,
  input  wire logic              HREAD_N,
  output logic                   HREADY_N,
  output logic                   HDATAOUT_EN_N,
  output logic [DATA_W-1:0]      HDATAOUT,
  input  wire logic [15:0]       TX_FIFO_DATA,
  input  wire logic [1:0]        TX_FIFO_BYTEN,
  input  wire logic              TX_FIFO_AVAIL,
  input  wire logic              TX_FIFO_EOF,
  input  wire logic              TX_FIFO_EMPTY,
  output logic                   TX_FIFO_READ,
  output logic                   TX_ERR,
  output mhtf_word_t             TX_OUT,
  output logic                   TX_OUT_VALID,
  input  wire logic              TX_OUT_READY
);

  // ************************************************************
  // State and decode
  // ************************************************************
  mhtf_state_t st_r;
  mhtf_state_t st_nxt;
  mhtf_word_t  buf_in;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic        sel_wr;
  logic        sel_rd;
  logic [15:0] wdata;

  // Select gates both strobes, and write takes priority if both are low.
  assign sel_wr = !HCS_N && !HWRITE_N;
  assign sel_rd = !HCS_N && !HREAD_N && HWRITE_N;
  assign wdata  = 16'(HDATAIN);

  function automatic logic [15:0] reg_read(input logic [7:0] addr, input mhtf_state_t s);
    logic [15:0] v;
    v = REG_ZERO;
    case (addr)
      ADDR_CTRL:    v = s.ctrl;
      ADDR_STAT:
      begin
        v[STAT_UNDERRUN_BIT] = s.underrun;
        v[STAT_INFRAME_BIT]  = s.in_frame;
      end
      ADDR_FRAMES:  v = s.frames;
      ADDR_SCRATCH: v = s.scratch;
      default:      v = REG_ZERO;
    endcase
    return v;
  endfunction : reg_read

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.rd_pulse = 1'b0;
    st_nxt.tx_err   = 1'b0;
    buf_in.data     = TX_FIFO_DATA;
    buf_in.byten    = TX_FIFO_BYTEN; // Lanes travel with the data unchanged.
    buf_in.last     = TX_FIFO_EOF || (TX_FIFO_BYTEN != BYTEN_FULL);
    buf_in_valid    = 1'b0;

    // Host port. Ready stays low until the host releases its strobe or its select.
    case (st_r.host_st)
      H_IDLE:
      begin
        if (sel_wr)
        begin
          case (HADDR)
            ADDR_CTRL:    st_nxt.ctrl = wdata;
            ADDR_STAT:
              if (wdata[STAT_UNDERRUN_BIT])
                st_nxt.underrun = 1'b0;
            ADDR_FRAMES:  st_nxt.frames = REG_ZERO;
            ADDR_SCRATCH: st_nxt.scratch = wdata;
            default:      st_nxt.scratch = st_r.scratch;
          endcase
          st_nxt.ready_n = 1'b0; // Same edge that stores the data.
          st_nxt.host_st = H_WDONE;
        end
        else if (sel_rd)
        begin
          st_nxt.dout      = reg_read(HADDR, st_r);
          st_nxt.dout_en_n = 1'b0;
          st_nxt.ready_n   = 1'b0;
          st_nxt.host_st   = H_RDONE;
        end
      end
      H_WDONE:
        if (HWRITE_N || HCS_N)
        begin
          st_nxt.ready_n = 1'b1;
          st_nxt.host_st = H_IDLE;
        end
      H_RDONE:
        if (HREAD_N || HCS_N)
        begin
          st_nxt.ready_n   = 1'b1;
          st_nxt.dout_en_n = 1'b1;
          st_nxt.dout      = REG_ZERO;
          st_nxt.host_st   = H_IDLE;
        end
      default: st_nxt.host_st = H_IDLE;
    endcase

    // Transmit feed. A read is issued only while a buffer slot is free; the
    // word then arrives one cycle later, so at most one request is in flight.
    case (st_r.feed_st)
      F_IDLE:
        if (st_r.ctrl[CTRL_TXEN_BIT] && TX_FIFO_AVAIL && !TX_FIFO_EMPTY && buf_in_ready)
        begin
          st_nxt.rd_pulse = 1'b1;
          st_nxt.feed_st  = F_CAPT;
        end
      F_REQ:
        if (TX_FIFO_EMPTY)
        begin
          st_nxt.tx_err   = 1'b1;
          st_nxt.underrun = 1'b1; // Set wins over a same-cycle clear.
          st_nxt.in_frame = 1'b0;
          st_nxt.feed_st  = F_IDLE;
        end
        else if (buf_in_ready)
        begin
          st_nxt.rd_pulse = 1'b1;
          st_nxt.feed_st  = F_CAPT;
        end
      F_CAPT:
      begin
        st_nxt.feed_st = F_REQ;
        if (TX_FIFO_BYTEN != BYTEN_NONE)
        begin
          buf_in_valid    = 1'b1;
          st_nxt.in_frame = 1'b1;
          if (buf_in.last)
          begin
            st_nxt.in_frame = 1'b0;
            st_nxt.frames   = st_nxt.frames + 16'h0001;
            st_nxt.feed_st  = F_IDLE;
          end
        end
      end
      default: st_nxt.feed_st = F_IDLE;
    endcase
  end

  // Everything runs on the one system clock; no crossing is needed.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      st_r <= ST_RST;
    else
      st_r <= st_nxt;
  end

  assign HREADY_N      = st_r.ready_n;
  assign HDATAOUT_EN_N = st_r.dout_en_n;
  assign HDATAOUT      = st_r.dout[DATA_W-1:0];
  assign TX_FIFO_READ  = st_r.rd_pulse;
  assign TX_ERR        = st_r.tx_err;

  // ************************************************************
  // Output buffer
  // ************************************************************
  mhtf_buf #(
    .W     ($bits(mhtf_word_t)),
    .DEPTH (2)
  ) u_buf (
    .clk       (REF_CLK),
    .rst       (RST),
    .in_data   (buf_in),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .out_data  (TX_OUT),
    .out_valid (TX_OUT_VALID),
    .out_ready (TX_OUT_READY)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  logic idle_h;
  assign idle_h = (st_r.host_st == H_IDLE);

  sequence s_wr_taken;
    idle_h && sel_wr;
  endsequence
  sequence s_rd_taken;
    idle_h && sel_rd;
  endsequence

  property p_wr_done;
    s_wr_taken |=> !HREADY_N && HDATAOUT_EN_N;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("Write not acknowledged next cycle.");

  property p_wr_store;
    s_wr_taken and (HADDR == ADDR_SCRATCH) |=> st_r.scratch == $past(wdata);
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("Write data not stored.");

  property p_rd_data;
    s_rd_taken and (HADDR == ADDR_SCRATCH) |=> !HDATAOUT_EN_N && !HREADY_N
      && HDATAOUT == $past(st_r.scratch[DATA_W-1:0]);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("Read data or done missing.");

  property p_en_valid;
    !HDATAOUT_EN_N && $past(!HDATAOUT_EN_N) |-> $stable(HDATAOUT) && !HREADY_N;
  endproperty
  a_en_valid: assert property (p_en_valid) else $error("Read data moved while enabled.");

  property p_unselected;
    idle_h && HCS_N |=> HREADY_N && HDATAOUT_EN_N;
  endproperty
  a_unselected: assert property (p_unselected) else $error("Access taken without select.");

  property p_read_pulse;
    TX_FIFO_READ |=> !TX_FIFO_READ;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("FIFO read longer than a cycle.");

  property p_empty_word;
    st_r.feed_st == F_CAPT && TX_FIFO_BYTEN == BYTEN_NONE |-> !buf_in_valid;
  endproperty
  a_empty_word: assert property (p_empty_word) else $error("Word without lanes accepted.");

  property p_short_end;
    buf_in_valid && TX_FIFO_BYTEN != BYTEN_FULL |-> buf_in.last ##1 st_r.feed_st == F_IDLE;
  endproperty
  a_short_end: assert property (p_short_end) else $error("Partial word did not end frame.");

  property p_underrun;
    st_r.feed_st == F_REQ && TX_FIFO_EMPTY |=> TX_ERR && !TX_FIFO_READ ##1 !TX_ERR;
  endproperty
  a_underrun: assert property (p_underrun) else $error("Under-run not flagged for one cycle.");

  property p_reset;
    disable iff (1'b0) RST |=> HREADY_N && HDATAOUT_EN_N && !TX_FIFO_READ && !TX_ERR;
  endproperty
  a_reset: assert property (p_reset) else $error("Outputs active after reset.");

endmodule : mhtf_top
